// ---- include/pdp_pkg.sv ----
// constants for the loop divider and charge pump configuration slice
package pdp_pkg;

    localparam int PDP_ADDR_W = 10;
    localparam int PDP_DATA_W = 8;

    // register offsets
    localparam logic [9:0] PDP_OFS_LOOP_CTRL = 10'h010;
    localparam logic [9:0] PDP_OFS_REF_LOW = 10'h011;
    localparam logic [9:0] PDP_OFS_REF_HIGH = 10'h012;
    localparam logic [9:0] PDP_OFS_SWALLOW = 10'h013;
    localparam logic [9:0] PDP_OFS_MAIN_LOW = 10'h014;

    // field positions in the loop control register
    localparam int PDP_PUMP_LSB = 2;
    localparam int PDP_POWER_LSB = 0;

    // field widths
    localparam int PDP_REF_HIGH_W = 6;
    localparam int PDP_SWALLOW_W = 6;

    // pump operating select codes
    localparam logic [1:0] PDP_PUMP_HIZ = 2'h0;
    localparam logic [1:0] PDP_PUMP_UP = 2'h1;
    localparam logic [1:0] PDP_PUMP_DOWN = 2'h2;
    localparam logic [1:0] PDP_PUMP_NORMAL = 2'h3;

    // loop power state codes
    localparam logic [1:0] PDP_PWR_NORMAL = 2'h0;
    localparam logic [1:0] PDP_PWR_ASYNC_PD = 2'h1;
    localparam logic [1:0] PDP_PWR_UNUSED = 2'h2;
    localparam logic [1:0] PDP_PWR_SYNC_PD = 2'h3;

    // values after reset
    localparam logic [1:0] PDP_RST_PUMP = PDP_PUMP_NORMAL;
    localparam logic [1:0] PDP_RST_POWER = PDP_PWR_ASYNC_PD;
    localparam logic [7:0] PDP_RST_REF_LOW = 8'h01;
    localparam logic [5:0] PDP_RST_REF_HIGH = 6'h00;
    localparam logic [5:0] PDP_RST_SWALLOW = 6'h00;
    localparam logic [7:0] PDP_RST_MAIN_LOW = 8'h03;

endpackage : pdp_pkg

// ---- logic/pdp_config.sv ----
// register slice for loop dividers, pump mode and loop power state
`timescale 1ns/1ns
`default_nettype none
module pdp_config
    import pdp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [9:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic pfd_up,
    input wire logic pfd_down,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic [13:0] ref_div_count,
    output logic [5:0] fb_swallow_count,
    output logic [7:0] fb_main_count_low,
    output logic [1:0] loop_power_state,
    output logic loop_run,
    output logic loop_sync_pd,
    output logic pump_source,
    output logic pump_sink,
    output logic pump_out_en
);

    logic [1:0] pump_op_ff;
    logic [1:0] power_ff;
    logic [7:0] ref_low_ff;
    logic [5:0] ref_high_ff;
    logic [5:0] swallow_ff;
    logic [7:0] main_low_ff;
    logic [7:0] rdata_ff;
    logic rvalid_ff;
    logic run_ff;
    logic sync_pd_ff;
    logic [7:0] nxt_rdata;

    function automatic logic fn_hit(input logic [9:0] addr, input logic [9:0] ofs);
        fn_hit = (addr == ofs);
    endfunction : fn_hit

    // loop control: pump select and power state
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pump_op_ff <= PDP_RST_PUMP;
            power_ff <= PDP_RST_POWER;
        end else if (reg_wr && fn_hit(reg_addr, PDP_OFS_LOOP_CTRL)) begin
            pump_op_ff <= reg_wdata[PDP_PUMP_LSB +: 2];
            power_ff <= reg_wdata[PDP_POWER_LSB +: 2];
        end
    end

    // reference divider, split over two bytes
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_low_ff <= PDP_RST_REF_LOW;
            ref_high_ff <= PDP_RST_REF_HIGH;
        end else if (reg_wr) begin
            if (fn_hit(reg_addr, PDP_OFS_REF_LOW)) begin
                ref_low_ff <= reg_wdata;
            end
            if (fn_hit(reg_addr, PDP_OFS_REF_HIGH)) begin
                ref_high_ff <= reg_wdata[PDP_REF_HIGH_W-1:0];
            end
        end
    end

    // feedback divider words
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            swallow_ff <= PDP_RST_SWALLOW;
            main_low_ff <= PDP_RST_MAIN_LOW;
        end else if (reg_wr) begin
            if (fn_hit(reg_addr, PDP_OFS_SWALLOW)) begin
                swallow_ff <= reg_wdata[PDP_SWALLOW_W-1:0];
            end
            if (fn_hit(reg_addr, PDP_OFS_MAIN_LOW)) begin
                main_low_ff <= reg_wdata;
            end
        end
    end

    // power state decode; the unused code is held powered down as the safe side
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_ff <= 1'b0;
            sync_pd_ff <= 1'b0;
        end else begin
            run_ff <= (power_ff == PDP_PWR_NORMAL);
            sync_pd_ff <= (power_ff == PDP_PWR_SYNC_PD);
        end
    end

    // read mux; unused bits and unmapped offsets read zero
    always_comb begin
        nxt_rdata = 8'h00;
        if (fn_hit(reg_addr, PDP_OFS_LOOP_CTRL)) begin
            nxt_rdata = {4'h0, pump_op_ff, power_ff};
        end else if (fn_hit(reg_addr, PDP_OFS_REF_LOW)) begin
            nxt_rdata = ref_low_ff;
        end else if (fn_hit(reg_addr, PDP_OFS_REF_HIGH)) begin
            nxt_rdata = {2'h0, ref_high_ff};
        end else if (fn_hit(reg_addr, PDP_OFS_SWALLOW)) begin
            nxt_rdata = {2'h0, swallow_ff};
        end else if (fn_hit(reg_addr, PDP_OFS_MAIN_LOW)) begin
            nxt_rdata = main_low_ff;
        end
    end

    // read data holds until the next read
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd;
            if (reg_rd) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    pdp_pump_drive u_pump (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pump_op(pump_op_ff),
        .loop_run(run_ff),
        .pfd_up(pfd_up),
        .pfd_down(pfd_down),
        .pump_source(pump_source),
        .pump_sink(pump_sink),
        .pump_out_en(pump_out_en)
    );

    assign reg_rdata = rdata_ff;
    assign reg_rvalid = rvalid_ff;
    assign ref_div_count = {ref_high_ff, ref_low_ff};
    assign fb_swallow_count = swallow_ff;
    assign fb_main_count_low = main_low_ff;
    assign loop_power_state = power_ff;
    assign loop_run = run_ff;
    assign loop_sync_pd = sync_pd_ff;

    AST_PUMP_SELECT_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_wr && reg_addr == PDP_OFS_LOOP_CTRL && reg_wdata[3:2] == PDP_PUMP_UP
        |=> ##1 pump_source && !pump_sink)
        else $error("written pump up select not applied in two cycles");

    AST_PUMP_DOWN_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_wr && reg_addr == PDP_OFS_LOOP_CTRL && reg_wdata[3:2] == PDP_PUMP_DOWN
        |=> ##1 pump_sink && !pump_source)
        else $error("written pump down select not applied in two cycles");

    AST_POWER_DECODE: assert property (@(posedge core_clk) disable iff (!rst_n)
        ##1 ((loop_run == ($past(power_ff) == PDP_PWR_NORMAL))
        && (loop_sync_pd == ($past(power_ff) == PDP_PWR_SYNC_PD))))
        else $error("power state decode wrong");

    AST_REF_LOW_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == PDP_OFS_REF_LOW |=> reg_rvalid
        && reg_rdata == $past(ref_div_count[7:0]))
        else $error("reference low byte read mismatch");

    AST_REF_HIGH_FIELD: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_wr && reg_addr == PDP_OFS_REF_HIGH
        |=> ref_div_count[13:8] == $past(reg_wdata[5:0]) ##1
        (!$past(reg_rd) || $past(reg_addr) != PDP_OFS_REF_HIGH || reg_rdata[7:6] == 2'h0))
        else $error("reference high field write wrong");

    AST_SWALLOW_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_wr && reg_addr == PDP_OFS_SWALLOW
        |=> fb_swallow_count == $past(reg_wdata[5:0]))
        else $error("swallow count write wrong");

    AST_MAIN_LOW_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        !(reg_wr && reg_addr == PDP_OFS_MAIN_LOW) |=> $stable(fb_main_count_low))
        else $error("main count low byte changed without a write");

    AST_MAIN_LOW_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_wr && reg_addr == PDP_OFS_MAIN_LOW |=> fb_main_count_low == $past(reg_wdata))
        else $error("main count low byte write wrong");

    // a lingering answer strobe would be taken as a second read
    AST_RVALID_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> reg_rvalid == $past(reg_rd))
        else $error("read answer strobe does not follow the read strobe");

    AST_CTRL_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_wr && reg_addr == PDP_OFS_LOOP_CTRL
        |=> loop_power_state == $past(reg_wdata[PDP_POWER_LSB +: 2]))
        else $error("power state field write wrong");

    AST_UNUSED_POWER_DOWN: assert property (@(posedge core_clk) disable iff (!rst_n)
        loop_power_state == PDP_PWR_UNUSED |=> !loop_run && !loop_sync_pd)
        else $error("unused power code left the loop running");

    // normal select with a stopped loop must neither source nor sink
    AST_NORMAL_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
        pump_op_ff == PDP_PUMP_NORMAL && !loop_run
        |=> pump_out_en && !pump_source && !pump_sink)
        else $error("normal select drove the pump with the loop stopped");

    AST_REF_LOW_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_wr && reg_addr == PDP_OFS_REF_LOW
        |=> ref_div_count[7:0] == $past(reg_wdata))
        else $error("reference low byte write wrong");

    AST_SWALLOW_READ: assert property (@(posedge core_clk) disable iff (!rst_n)
        reg_rd && reg_addr == PDP_OFS_SWALLOW
        |=> reg_rdata == {2'h0, $past(fb_swallow_count)})
        else $error("swallow count read mismatch");

endmodule : pdp_config
`default_nettype wire

// ---- logic/pdp_pump_drive.sv ----
// charge pump drive selection from the pump operating select field
`timescale 1ns/1ns
`default_nettype none
module pdp_pump_drive
    import pdp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] pump_op,
    input wire logic loop_run,
    input wire logic pfd_up,
    input wire logic pfd_down,
    output logic pump_source,
    output logic pump_sink,
    output logic pump_out_en
);

    logic nxt_source;
    logic nxt_sink;
    logic nxt_en;

    always_comb begin
        nxt_source = 1'b0;
        nxt_sink = 1'b0;
        nxt_en = 1'b1;
        case (pump_op)
            PDP_PUMP_HIZ: begin
                nxt_en = 1'b0;
            end
            PDP_PUMP_UP: begin
                nxt_source = 1'b1;
            end
            PDP_PUMP_DOWN: begin
                nxt_sink = 1'b1;
            end
            PDP_PUMP_NORMAL: begin
                // phase detector only steers a running loop
                nxt_source = pfd_up & loop_run;
                nxt_sink = pfd_down & loop_run;
            end
            default: begin
                nxt_en = 1'b0;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pump_source <= 1'b0;
            pump_sink <= 1'b0;
            pump_out_en <= 1'b1;
        end else begin
            pump_source <= nxt_source;
            pump_sink <= nxt_sink;
            pump_out_en <= nxt_en;
        end
    end

    AST_FORCED_UP: assert property (@(posedge core_clk) disable iff (!rst_n)
        pump_op == PDP_PUMP_UP |=> pump_source && !pump_sink && pump_out_en)
        else $error("forced up mode did not source");

    AST_FORCED_DOWN: assert property (@(posedge core_clk) disable iff (!rst_n)
        pump_op == PDP_PUMP_DOWN |=> pump_sink && !pump_source && pump_out_en)
        else $error("forced down mode did not sink");

    AST_HIZ_NORMAL: assert property (@(posedge core_clk) disable iff (!rst_n)
        (pump_op == PDP_PUMP_HIZ |=> !pump_out_en && !pump_source && !pump_sink)
        and (pump_op == PDP_PUMP_NORMAL && loop_run |=>
            pump_source == $past(pfd_up) && pump_sink == $past(pfd_down)))
        else $error("hiz or normal pump mode wrong");

endmodule : pdp_pump_drive
`default_nettype wire

// ---- verification/pdp_config_tb.sv ----
// self-checking bench for the loop divider and pump configuration slice
`timescale 1ns/1ns
`default_nettype none
module pdp_config_tb;
    import pdp_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] reg_addr = 10'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic pfd_up = 1'b0;
    logic pfd_down = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    logic [13:0] ref_div_count;
    logic [5:0] fb_swallow_count;
    logic [7:0] fb_main_count_low;
    logic [1:0] loop_power_state;
    logic loop_run;
    logic loop_sync_pd;
    logic pump_source;
    logic pump_sink;
    logic pump_out_en;
    int error_cnt = 0;
    int n_compared = 0;
    int cyc_cnt = 0;
    logic [31:0] rnd_ff = 32'h34F0;

    pdp_config i_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .pfd_up(pfd_up),
        .pfd_down(pfd_down), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .ref_div_count(ref_div_count), .fb_swallow_count(fb_swallow_count),
        .fb_main_count_low(fb_main_count_low), .loop_power_state(loop_power_state),
        .loop_run(loop_run), .loop_sync_pd(loop_sync_pd), .pump_source(pump_source),
        .pump_sink(pump_sink), .pump_out_en(pump_out_en));

    always #50 core_clk = ~core_clk;

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // hang guard: whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            final_report();
        end
    end

    function automatic logic [7:0] nxt_rnd();
        logic [31:0] x;
        x = rnd_ff;
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        rnd_ff = x;
        return x[7:0];
    endfunction : nxt_rnd

    // expected {source, sink, enable} of the pump
    function automatic logic [2:0] exp_pump(logic [1:0] sel, logic [1:0] pwr, logic up,
                                            logic dn);
        logic run;
        run = (pwr == PDP_PWR_NORMAL);
        case (sel)
            PDP_PUMP_HIZ: return 3'h0;
            PDP_PUMP_UP: return 3'h5;
            PDP_PUMP_DOWN: return 3'h3;
            default: return {up & run, dn & run, 1'b1};
        endcase
    endfunction : exp_pump

    // read-back value: unused top bits of 0x012 and 0x013 are not stored
    function automatic logic [7:0] exp_rd(int i, logic [7:0] v);
        return (i == 1 || i == 2) ? (v & 8'h3F) : v;
    endfunction : exp_rd

    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // back to back capable: caller drops reg_wr after the last write
    task automatic wr(logic [9:0] a, logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
    endtask : wr

    task automatic rd(logic [9:0] a, output logic [7:0] d);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
        check("rvalid", 16'(reg_rvalid), 16'h0001);
        @(negedge core_clk);
        check("rvalid drop", 16'(reg_rvalid), 16'h0000);
    endtask : rd

    initial begin
        logic [7:0] d;
        logic [7:0] v[4];
        logic [7:0] rst_tab[5];
        logic [1:0] sel;
        logic [1:0] pwr;
        rst_tab = '{8'h0D, 8'h01, 8'h00, 8'h00, 8'h03};
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        check("ref_div", 16'(ref_div_count), 16'h0001);
        check("swallow", 16'(fb_swallow_count), 16'h0000);
        check("main_low", 16'(fb_main_count_low), 16'h0003);
        check("power", 16'(loop_power_state), 16'h0001);
        check("pump", 16'({pump_source, pump_sink, pump_out_en}), 16'h0001);
        for (int i = 0; i < 5; i++) begin
            rd(10'(PDP_OFS_LOOP_CTRL + i), d);
            check("reset read", 16'(d), 16'(rst_tab[i]));
        end
        $display("test reset values done");
        for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 4; i++) begin
                v[i] = (k == 0) ? 8'hFF : nxt_rnd();
                wr(10'(PDP_OFS_REF_LOW + i), v[i]);
            end
            wr((k == 0) ? 10'h3FF : 10'h015, nxt_rnd());
            reg_wr = 1'b0;
            check("ref_div", 16'(ref_div_count), 16'({v[1][5:0], v[0]}));
            check("swallow", 16'(fb_swallow_count), 16'(v[2][5:0]));
            check("main_low", 16'(fb_main_count_low), 16'(v[3]));
            for (int i = 0; i < 4; i++) begin
                rd(10'(PDP_OFS_REF_LOW + i), d);
                check("div read", 16'(d), 16'(exp_rd(i, v[i])));
            end
            rd(10'h015, d);
            check("unmapped read", 16'(d), 16'h0000);
        end
        $display("test divider registers done");
        for (int m = 0; m < 16; m++) begin
            sel = 2'(m >> 2);
            pwr = 2'(m);
            wr(PDP_OFS_LOOP_CTRL, {nxt_rnd() & 8'hF0} | {4'h0, sel, pwr});
            reg_wr = 1'b0;
            @(negedge core_clk);
            check("loop_run", 16'(loop_run), 16'(pwr == PDP_PWR_NORMAL));
            check("sync_pd", 16'(loop_sync_pd), 16'(pwr == PDP_PWR_SYNC_PD));
            check("power", 16'(loop_power_state), 16'(pwr));
            for (int p = 0; p < 4; p++) begin
                pfd_up = p[0];
                pfd_down = p[1];
                @(negedge core_clk);
                check("pump", 16'({pump_source, pump_sink, pump_out_en}),
                      16'(exp_pump(sel, pwr, p[0], p[1])));
            end
            rd(PDP_OFS_LOOP_CTRL, d);
            check("ctrl read", 16'(d), 16'({4'h0, sel, pwr}));
        end
        $display("test pump and power modes done");
        final_report();
    end
endmodule : pdp_config_tb
`default_nettype wire
